/* File: common/cda_pkg.sv */
// Package: offsets, fields and reset values of the channel-disable/accumulation-count bank
package cda_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0]  ADDR_REFRESH         = 8'h00;
	localparam logic [7:0]  ADDR_SAMPLING_CONTROL = 8'h01;
	localparam logic [7:0]  ADDR_ACCUM_COUNT     = 8'h02;
	localparam logic [7:0]  ADDR_CH1_FIRST       = 8'h03;
	localparam logic [7:0]  ADDR_CH_GROUP_LAST   = 8'h0E;
	localparam logic [7:0]  ADDR_GROUP_STRIDE    = 8'h04;
	// ---------------------------------------------------------------
	// Fields
	// ---------------------------------------------------------------
	localparam int          CHOFF_LSB            = 4;
	localparam int          CHOFF_MSB            = 7;
	localparam int          NOSKIP_BIT           = 1;
	localparam int          NUM_CH               = 4;
	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] CONTROL_UPPER_RESET  = 16'h0700;
	localparam logic [3:0]  CHOFF_RESET_4CH      = 4'h0;
	localparam logic [3:0]  CHOFF_RESET_3CH      = 4'h1;
	localparam logic [3:0]  CHOFF_RESET_2CH      = 4'h3;
	localparam logic [3:0]  CHOFF_RESET_1CH      = 4'h7;
	localparam logic [31:0] ACCUM_COUNT_RESET    = 32'h0000_0000;
	localparam logic [1:0]  SLOT_COUNT_RESET     = 2'h0;
endpackage : cda_pkg

/* File: hw/cda_channel_bank.sv */
// Channel disable field, conversion slot sequencer, pointer skip and accumulation count
`timescale 1ns/1ps

// Behaviour
// - Set disable bit removes channel from conversion; cleared bit keeps it active.
// - Disable settings apply to round-robin and single-shot conversions alike.
// - Auto-increment pointer skips inactive channel addresses unless no-skip bit set.
// - Channel one is bit 3, down to channel four at bit 0.
// - Fewer active channels give a shorter conversion cycle.
// - Disable field resets by populated channel count: 0000, 0001, 0011, 0111.
// - Control register bits 3-0 store nothing and read zero.
// - 32-bit count advances per accumulated power result; cleared at power-on.
// - Written control values read back at once, before any refresh.
module cda_channel_bank
	import cda_pkg::*;
#(
	parameter int unsigned POPULATED = 4
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        clockEnable,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWriteData,
	input  wire logic        refreshCmd,
	input  wire logic        noSkip,
	input  wire logic        singleShot,
	input  wire logic        convStart,
	input  wire logic        slotDone,
	input  wire logic        accumAdd,
	input  wire logic        pointerStep,
	output logic      [31:0] regReadData,
	output logic      [7:0]  pointer,
	output logic      [3:0]  activeChannels,
	output logic      [1:0]  convSlot,
	output logic             convBusy,
	output logic             cycleDone
);
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [3:0] choffReset(input int unsigned n);
		case (n)
			1:       choffReset = CHOFF_RESET_1CH;
			2:       choffReset = CHOFF_RESET_2CH;
			3:       choffReset = CHOFF_RESET_3CH;
			default: choffReset = CHOFF_RESET_4CH;
		endcase
	endfunction : choffReset

	// Disable bit of a channel index 0..3 (channel one at bit 3)
	function automatic logic chOff(input logic [3:0] f, input logic [1:0] ch);
		chOff = f[2'd3 - ch];
	endfunction : chOff

	// Lowest-index active channel of a disable field
	function automatic logic [1:0] firstActive(input logic [3:0] f);
		firstActive = 2'd0;
		for (int i = NUM_CH - 1; i >= 0; i--)
			if (!chOff(f, 2'(i)))
				firstActive = 2'(i);
	endfunction : firstActive

	// Channel owning a per-channel address, or none for control registers
	function automatic logic [2:0] addrChannel(input logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		if (a >= ADDR_CH1_FIRST && a <= ADDR_CH_GROUP_LAST) begin
			d = a - ADDR_CH1_FIRST;
			addrChannel = {1'b1, d[1:0]};
		end else begin
			addrChannel = 3'b000;
		end
	endfunction : addrChannel

	localparam logic [3:0] CHOFF_INIT = choffReset(POPULATED);

	typedef enum logic [1:0] {CDA_IDLE, CDA_RUN} cda_state_t;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0]  controlUpper, next_controlUpper;
	logic [3:0]  chOffShadow, next_chOffShadow;
	logic [3:0]  chOffLive, next_chOffLive;
	logic [31:0] accCount, next_accCount;
	logic [7:0]  next_pointer;
	logic [31:0] next_regReadData;
	logic [1:0]  next_convSlot;
	logic        next_convBusy, next_cycleDone;
	cda_state_t  state, next_state;

	always_comb begin
		logic [1:0] s;
		logic [2:0] pc;
		logic       found;
		s = 2'd0;
		pc = 3'd0;
		found = 1'b0;
		next_controlUpper = controlUpper;
		next_chOffShadow = chOffShadow;
		next_chOffLive   = chOffLive;
		next_accCount    = accCount;
		next_pointer     = pointer;
		next_regReadData = regReadData;
		next_convSlot    = convSlot;
		next_convBusy    = convBusy;
		next_cycleDone   = 1'b0;
		next_state       = state;
		if (accumAdd)
			next_accCount = accCount + 32'h0000_0001;
		if (regWrite) begin
			next_pointer = regAddr;
			if (regAddr == ADDR_SAMPLING_CONTROL) begin
				next_controlUpper = regWriteData[15:8];
				next_chOffShadow = regWriteData[CHOFF_MSB:CHOFF_LSB];
			end else if (regAddr == ADDR_ACCUM_COUNT) begin
				next_accCount = regWriteData;
			end
		end
		if (refreshCmd)
			next_chOffLive = chOffShadow;
		if (regRead) begin
			case (regAddr)
				ADDR_SAMPLING_CONTROL: next_regReadData = {16'h0000, controlUpper, chOffShadow, 4'h0};
				ADDR_ACCUM_COUNT:      next_regReadData = accCount;
				default:               next_regReadData = 32'h0000_0000;
			endcase
		end
		if (pointerStep) begin
			next_pointer = pointer + 8'h01;
			pc = addrChannel(pointer + 8'h01);
			// Step over whole runs of inactive-channel addresses
			for (int i = 0; i < NUM_CH * 3; i++) begin
				if (!found) begin
					pc = addrChannel(next_pointer);
					if (!noSkip && pc[2] && chOff(chOffLive, pc[1:0]))
						next_pointer = next_pointer + 8'h01;
					else
						found = 1'b1;
				end
			end
		end
		case (state)
			CDA_IDLE: begin
				if (convStart && chOffLive != 4'hF) begin
					next_convSlot = firstActive(chOffLive);
					next_convBusy = 1'b1;
					next_state    = CDA_RUN;
				end
			end
			CDA_RUN: begin
				if (slotDone) begin
					found = 1'b0;
					// Advance to the next active channel; fewer channels, shorter cycle
					for (int i = NUM_CH - 1; i >= 0; i--) begin
						if (2'(i) > convSlot && !chOff(chOffLive, 2'(i))) begin
							s = 2'(i);
							found = 1'b1;
						end
					end
					if (found) begin
						next_convSlot = s;
					end else begin
						next_cycleDone = 1'b1;
						if (singleShot || !convStart || chOffLive == 4'hF) begin
							next_convBusy = 1'b0;
							next_state    = CDA_IDLE;
						end else begin
							// Round-robin: start over at the first active channel
							next_convSlot = firstActive(chOffLive);
						end
					end
				end
			end
			default: next_state = CDA_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			controlUpper   <= CONTROL_UPPER_RESET[15:8];
			chOffShadow    <= CHOFF_INIT;
			chOffLive      <= CHOFF_INIT;
			accCount       <= ACCUM_COUNT_RESET;
			pointer        <= ADDR_REFRESH;
			regReadData    <= 32'h0000_0000;
			convSlot       <= SLOT_COUNT_RESET;
			convBusy       <= 1'b0;
			cycleDone      <= 1'b0;
			activeChannels <= ~CHOFF_INIT;
			state          <= CDA_IDLE;
		end else if (clockEnable) begin
			controlUpper   <= next_controlUpper;
			chOffShadow    <= next_chOffShadow;
			chOffLive      <= next_chOffLive;
			accCount       <= next_accCount;
			pointer        <= next_pointer;
			regReadData    <= next_regReadData;
			convSlot       <= next_convSlot;
			convBusy       <= next_convBusy;
			cycleDone      <= next_cycleDone;
			activeChannels <= ~next_chOffLive;
			state          <= next_state;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence controlWrite_s;
		clockEnable && regWrite && regAddr == ADDR_SAMPLING_CONTROL;
	endsequence
	chk_control_readback: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && regRead && regAddr == ADDR_SAMPLING_CONTROL && !regWrite
		|=> regReadData[7:4] == $past(chOffShadow))
		else $error("control readback differs from stored field");
	chk_low_zero: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && regRead && regAddr == ADDR_SAMPLING_CONTROL |=> regReadData[3:0] == 4'h0)
		else $error("control low nibble not zero");
	chk_count_step: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && accumAdd && !regWrite |=> accCount == $past(accCount) + 32'h0000_0001)
		else $error("accumulation count did not advance");
	chk_live_hold: assert property (@(posedge clock) disable iff (!rst_n)
		controlWrite_s ##0 !refreshCmd |=> activeChannels == $past(activeChannels))
		else $error("disable setting took effect before refresh");
	chk_live_load: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && refreshCmd |=> activeChannels == ~$past(chOffShadow))
		else $error("refresh did not load disable field");
	chk_slot_active: assert property (@(posedge clock) disable iff (!rst_n)
		convBusy |-> !chOff(chOffLive, convSlot) || $past(refreshCmd))
		else $error("disabled channel converted");
	chk_skip_off: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && pointerStep && !regWrite && noSkip |=> pointer == $past(pointer) + 8'h01)
		else $error("pointer skipped with no-skip set");
	chk_skip_lands: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && pointerStep && !regWrite && !noSkip && !refreshCmd
		|=> !(addrChannel(pointer) != 3'b000 && chOff(chOffLive, 2'(pointer - ADDR_CH1_FIRST))))
		else $error("pointer landed on inactive channel");
endmodule : cda_channel_bank

/* File: testbench/cda_host_model.sv */
// Host controller model issuing register accesses and refreshes
`timescale 1ns/1ps
module cda_host_model #(
	parameter int WAIT_CYC = 10000
) (
	input  wire logic        clock,
	input  wire logic [31:0] regReadData,
	output logic             regWrite,
	output logic             regRead,
	output logic             refreshCmd,
	output logic      [7:0]  regAddr,
	output logic      [31:0] regWriteData
);
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		refreshCmd = 1'b0;
		regAddr = 8'h00;
		regWriteData = 32'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clock);
		regAddr = a;
		regWriteData = d;
		regWrite = 1'b1;
		@(negedge clock);
		regWrite = 1'b0;
		regWriteData = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clock);
		regAddr = a;
		regRead = 1'b1;
		@(negedge clock);
		regRead = 1'b0;
		@(negedge clock);
		d = regReadData;
	endtask : rd
	task automatic refresh;
		@(negedge clock);
		refreshCmd = 1'b1;
		@(negedge clock);
		refreshCmd = 1'b0;
		repeat (WAIT_CYC) @(negedge clock);
	endtask : refresh
endmodule : cda_host_model

/* File: testbench/channel_disable_and_accum_count_test.sv */
// Testbench of the channel disable field and accumulation count bank
`timescale 1ns/1ps
module channel_disable_and_accum_count_test;
	import cda_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} cda_row_t;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        clockEnable = 1'b1;
	logic        noSkip = 1'b0;
	logic        singleShot = 1'b0;
	logic        convStart = 1'b0;
	logic        slotDone = 1'b0;
	logic        accumAdd = 1'b0;
	logic        pointerStep = 1'b0;
	logic        regWrite, regRead, refreshCmd, convBusy, cycleDone, seen;
	logic [7:0]  regAddr, pointer;
	logic [31:0] regWriteData, regReadData, regReadData2, got;
	logic [3:0]  activeChannels, activeChannels2;
	logic [1:0]  convSlot;
	int          nFail = 0;
	int          samplesChecked = 0;
	cda_row_t    rows [4] = '{'{8'h01, 32'h0745, 32'h0740}, '{8'h01, 32'hFFFF_FFFF, 32'hFFF0},
		'{8'h20, 32'h1234, 32'h0}, '{8'h02, 32'hDEAD_BEEF, 32'hDEAD_BEEF}};
	always #50 clock = ~clock;
	cda_channel_bank #(.POPULATED(4)) DUT (.clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
		.refreshCmd(refreshCmd), .noSkip(noSkip), .singleShot(singleShot), .convStart(convStart),
		.slotDone(slotDone), .accumAdd(accumAdd), .pointerStep(pointerStep), .regReadData(regReadData),
		.pointer(pointer), .activeChannels(activeChannels), .convSlot(convSlot), .convBusy(convBusy),
		.cycleDone(cycleDone));
	// Two-channel part: only its reset values are checked
	cda_channel_bank #(.POPULATED(2)) DUT2 (.clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
		.refreshCmd(refreshCmd), .noSkip(noSkip), .singleShot(singleShot), .convStart(convStart),
		.slotDone(slotDone), .accumAdd(accumAdd), .pointerStep(pointerStep), .regReadData(regReadData2),
		.pointer(), .activeChannels(activeChannels2), .convSlot(), .convBusy(), .cycleDone());
	cda_host_model host (.clock(clock), .regReadData(regReadData), .regWrite(regWrite), .regRead(regRead),
		.refreshCmd(refreshCmd), .regAddr(regAddr), .regWriteData(regWriteData));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samplesChecked++;
		if (g !== e) begin
			nFail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wrapUp;
		if (nFail == 0 && samplesChecked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrapUp
	task automatic pulse(ref logic s);
		@(negedge clock);
		s = 1'b1;
		@(negedge clock);
		s = 1'b0;
		@(negedge clock);
	endtask : pulse
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (3) @(negedge clock);
		rst_n = 1'b1;
		host.rd(8'h01, got);
		chk(got, 32'h0700);
		chk(regReadData2, 32'h0730);
		chk({28'h0, activeChannels}, {28'h0, ~CHOFF_RESET_4CH});
		chk({28'h0, activeChannels2}, {28'h0, ~CHOFF_RESET_2CH});
		host.rd(8'h02, got);
		chk(got, 32'h0);
		foreach (rows[i]) begin
			host.wr(rows[i].a, rows[i].d);
			host.rd(rows[i].a, got);
			chk(got, rows[i].e);
		end
		host.wr(8'h01, 32'h0749);
		chk({28'h0, activeChannels}, 32'hF);
		pulse(accumAdd);
		pulse(accumAdd);
		host.refresh();
		chk({28'h0, activeChannels}, 32'hB);
		// Frozen clock enable: this add must not count
		clockEnable = 1'b0;
		pulse(accumAdd);
		clockEnable = 1'b1;
		host.rd(8'h02, got);
		chk(got, 32'hDEAD_BEF1);
		singleShot = 1'b1;
		pulse(convStart);
		chk({29'h0, convBusy, convSlot}, 32'h4);
		pulse(slotDone);
		chk({30'h0, convSlot}, 32'h2);
		pulse(slotDone);
		chk({30'h0, convSlot}, 32'h3);
		// Start request at the last slot must not restart a single shot
		@(negedge clock);
		slotDone = 1'b1;
		convStart = 1'b1;
		@(negedge clock);
		slotDone = 1'b0;
		convStart = 1'b0;
		seen = 1'b0;
		repeat (4) begin
			if (cycleDone === 1'b1)
				seen = 1'b1;
			@(negedge clock);
		end
		chk({30'h0, seen, convBusy}, 32'h2);
		// Round-robin: the cycle wraps to the first active channel
		singleShot = 1'b0;
		convStart = 1'b1;
		repeat (2) pulse(slotDone);
		@(negedge clock);
		slotDone = 1'b1;
		@(negedge clock);
		slotDone = 1'b0;
		chk({28'h0, cycleDone, convBusy, convSlot}, 32'hC);
		convStart = 1'b0;
		host.wr(8'h03, 32'h0);
		pulse(pointerStep);
		chk({24'h0, pointer}, 32'h05);
		noSkip = 1'b1;
		host.wr(8'h03, 32'h0);
		pulse(pointerStep);
		chk({24'h0, pointer}, 32'h04);
		// Second reset in mid-run
		@(negedge clock);
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		chk({19'h0, pointer, convBusy, activeChannels}, {19'h0, ADDR_REFRESH, 1'b0, ~CHOFF_RESET_4CH});
		host.rd(8'h02, got);
		chk(got, ACCUM_COUNT_RESET);
		host.rd(8'h01, got);
		chk(got, {16'h0000, CONTROL_UPPER_RESET[15:8], CHOFF_RESET_4CH, 4'h0});
		wrapUp();
	end
	initial begin
		#(100 * 20000);
		nFail++;
		wrapUp();
	end
endmodule : channel_disable_and_accum_count_test
